// ---- logic/hs_defines.vh ----
// Constants for the homing sequencer: method codes, step table layout,
// switch indexes, sequence identifiers and reset values.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef HS_DEFINES_VH
`define HS_DEFINES_VH

////////////////////////////////////////////////////////////////////////
// Homing method codes
`define HS_M16            8'h10
`define HS_M17            8'h11
`define HS_M18            8'h12
`define HS_M19            8'h13
`define HS_M20            8'h14
`define HS_M21            8'h15
`define HS_M22            8'h16
`define HS_M23            8'h17
`define HS_M24            8'h18
`define HS_M25            8'h19
`define HS_M26            8'h1A
`define HS_M27            8'h1B
`define HS_METHOD_RST     8'h00

////////////////////////////////////////////////////////////////////////
// Step word: {last, high, fwd, sig[1:0], rise}
`define HS_ST_W           6
`define HS_ST_LAST        5
`define HS_ST_HIGH        4
`define HS_ST_FWD         3
`define HS_ST_SIG_HI      2
`define HS_ST_SIG_LO      1
`define HS_ST_RISE        0
`define HS_END            1'h1
`define HS_GO             1'h0
`define HS_HI             1'h1
`define HS_LO             1'h0
`define HS_FW             1'h1
`define HS_RV             1'h0
`define HS_RISE           1'h1
`define HS_FALL           1'h0

////////////////////////////////////////////////////////////////////////
// Switch indexes into the synchronised input vector
`define HS_SIG_HOME       2'h0
`define HS_SIG_FLIM       2'h1
`define HS_SIG_RLIM       2'h2

////////////////////////////////////////////////////////////////////////
// Motion sequences shared between methods and branches
`define HS_SQ_17A         4'h0
`define HS_SQ_17B         4'h1
`define HS_SQ_18A         4'h2
`define HS_SQ_18B         4'h3
`define HS_SQ_HF_R_LR_F   4'h4
`define HS_SQ_LR_F        4'h5
`define HS_SQ_20A         4'h6
`define HS_SQ_20B         4'h7
`define HS_SQ_HR_R_LF_F   4'h8
`define HS_SQ_LF_F        4'h9
`define HS_SQ_22A         4'hA
`define HS_SQ_22B         4'hB
`define HS_SQ_23C         4'hC
`define HS_SQ_24C         4'hD
`define HS_SQ_HF_F_LR_R   4'hE
`define HS_SQ_26AB        4'hF
`define HS_SQ_RST         4'h0

`endif

// ---- logic/hs_sync_edge.v ----
// Two-stage synchroniser for one switch input with edge detection.
// Assumes the input is asynchronous to clk; edges are one-cycle pulses.
`timescale 1ns/100ps

module hs_sync_edge
(
   input  wire clk,
   input  wire rst,
   input  wire ce,
   input  wire din,
   output wire level,
   output wire rise,
   output wire fall
);

   reg meta;
   reg stable;
   reg last;

   ////////////////////////////////////////////////////////////////////
   // First stage feeds only the second stage
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta   <= 1'h0;
         stable <= 1'h0;
         last   <= 1'h0;
      end
      else if (ce)
      begin
         meta   <= din;
         stable <= meta;
         last   <= stable;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Edges compare the settled stage with its delayed copy
   assign level = stable;
   assign rise  = stable & ~last;
   assign fall  = ~stable & last;

endmodule // hs_sync_edge

// ---- logic/hs_homing_sequencer.v ----
// Homing sequencer for homing methods 17 to 27 of a servo axis.
// Assumes METHOD, START and AT_ZERO come from logic on MCLK; the
// home and limit switches are asynchronous pins.
`timescale 1ns/100ps
`include "hs_defines.vh"

module hs_homing_sequencer
(
   input  wire       MCLK,
   input  wire       RST,
   input  wire       CE,
   input  wire       START,
   input  wire [7:0] METHOD,
   input  wire       HOME_SW,
   input  wire       FWD_LIMIT,
   input  wire       REV_LIMIT,
   input  wire       AT_ZERO,
   output reg        MOVE,
   output reg        MOVE_FWD,
   output reg        MOVE_HIGH,
   output reg        BRAKE,
   output reg        BUSY,
   output reg        DONE,
   output reg        ERROR
);

   localparam ST_IDLE   = 2'h0;
   localparam ST_SEARCH = 2'h1;
   localparam ST_BRAKE  = 2'h2;

   reg  [1:0]         state;
   reg  [7:0]         method;
   reg  [3:0]         seq;
   reg  [1:0]         idx;
   reg                escaped;
   wire [2:0]         raw_sw;
   wire [2:0]         sw_level;
   wire [2:0]         sw_rise;
   wire [2:0]         sw_fall;
   wire [`HS_ST_W-1:0] cur;
   wire [1:0]         cur_sig;
   wire               hit;
   wire [6:0]         esc;
   wire               escape_now;
   wire [1:0]         dir_lim;
   wire               lim_fault;
   wire               start_ok;

   ////////////////////////////////////////////////////////////////////
   // Helpers
   function pick;
      input [2:0] vec;
      input [1:0] sel;
      begin
         case (sel)
            `HS_SIG_HOME: pick = vec[0];
            `HS_SIG_FLIM: pick = vec[1];
            `HS_SIG_RLIM: pick = vec[2];
            default:      pick = 1'h0;
         endcase
      end
   endfunction

   function [`HS_ST_W-1:0] st;
      input       last;
      input       high;
      input       fwd;
      input [1:0] sig;
      input       rise;
      begin
         st = {last, high, fwd, sig, rise};
      end
   endfunction

   // Method 16 and anything outside 17..27 never moves the axis
   function method_ok;
      input [7:0] m;
      begin
         method_ok = (m >= `HS_M17) && (m <= `HS_M27) && (m != `HS_M16);
      end
   endfunction

   // Which switch decides the starting branch
   function [1:0] start_sig;
      input [7:0] m;
      begin
         case (m)
            `HS_M17: start_sig = `HS_SIG_RLIM;
            `HS_M18: start_sig = `HS_SIG_FLIM;
            default: start_sig = `HS_SIG_HOME;
         endcase
      end
   endfunction

   function [3:0] pick_seq;
      input [7:0] m;
      input       act;
      begin
         case (m)
            `HS_M17: pick_seq = act ? `HS_SQ_17B : `HS_SQ_17A;
            `HS_M18: pick_seq = act ? `HS_SQ_18B : `HS_SQ_18A;
            `HS_M19: pick_seq = act ? `HS_SQ_LR_F : `HS_SQ_HF_R_LR_F;
            `HS_M20: pick_seq = act ? `HS_SQ_20B : `HS_SQ_20A;
            `HS_M21: pick_seq = act ? `HS_SQ_LF_F : `HS_SQ_HR_R_LF_F;
            `HS_M22: pick_seq = act ? `HS_SQ_22B : `HS_SQ_22A;
            `HS_M23: pick_seq = act ? `HS_SQ_LR_F : `HS_SQ_HF_R_LR_F;
            `HS_M24: pick_seq = act ? `HS_SQ_20B : `HS_SQ_20A;
            `HS_M25: pick_seq = `HS_SQ_HF_F_LR_R;
            `HS_M26: pick_seq = `HS_SQ_26AB;
            `HS_M27: pick_seq = act ? `HS_SQ_LF_F : `HS_SQ_HR_R_LF_F;
            default: pick_seq = `HS_SQ_RST;
         endcase
      end
   endfunction

   // Limit escape: {present, limit watched, sequence after the limit}
   function [6:0] esc_of;
      input [7:0] m;
      begin
         case (m)
            `HS_M23: esc_of = {1'h1, `HS_SIG_FLIM, `HS_SQ_23C};
            `HS_M24: esc_of = {1'h1, `HS_SIG_FLIM, `HS_SQ_24C};
            `HS_M25: esc_of = {1'h1, `HS_SIG_FLIM, `HS_SQ_22A};
            `HS_M26: esc_of = {1'h1, `HS_SIG_FLIM, `HS_SQ_HR_R_LF_F};
            `HS_M27: esc_of = {1'h1, `HS_SIG_RLIM, `HS_SQ_HF_F_LR_R};
            default: esc_of = {1'h0, `HS_SIG_HOME, `HS_SQ_RST};
         endcase
      end
   endfunction

   // Step table: every high-speed step not ended by a limit fault is followed by a brake to zero
   function [`HS_ST_W-1:0] step_of;
      input [3:0] s;
      input [1:0] i;
      begin
         case ({s, i})
            {`HS_SQ_17A, 2'h0}:       step_of = st(`HS_GO, `HS_HI, `HS_RV, `HS_SIG_RLIM, `HS_RISE);
            {`HS_SQ_17A, 2'h1}:       step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_RLIM, `HS_FALL);
            {`HS_SQ_17B, 2'h0}:       step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_RLIM, `HS_FALL);
            {`HS_SQ_18A, 2'h0}:       step_of = st(`HS_GO, `HS_HI, `HS_FW, `HS_SIG_FLIM, `HS_RISE);
            {`HS_SQ_18A, 2'h1}:       step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_FLIM, `HS_FALL);
            {`HS_SQ_18B, 2'h0}:       step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_FLIM, `HS_FALL);
            {`HS_SQ_HF_R_LR_F, 2'h0}: step_of = st(`HS_GO, `HS_HI, `HS_FW, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_HF_R_LR_F, 2'h1}: step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_LR_F, 2'h0}:      step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_20A, 2'h0}:       step_of = st(`HS_GO, `HS_HI, `HS_FW, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_20A, 2'h1}:       step_of = st(`HS_GO, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_20A, 2'h2}:       step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_20B, 2'h0}:       step_of = st(`HS_GO, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_20B, 2'h1}:       step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_HR_R_LF_F, 2'h0}: step_of = st(`HS_GO, `HS_HI, `HS_RV, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_HR_R_LF_F, 2'h1}: step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_LF_F, 2'h0}:      step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_22A, 2'h0}:       step_of = st(`HS_GO, `HS_HI, `HS_RV, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_22A, 2'h1}:       step_of = st(`HS_GO, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_22A, 2'h2}:       step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_22B, 2'h0}:       step_of = st(`HS_GO, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_22B, 2'h1}:       step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_23C, 2'h0}:       step_of = st(`HS_GO, `HS_HI, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_23C, 2'h1}:       step_of = st(`HS_GO, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_23C, 2'h2}:       step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_24C, 2'h0}:       step_of = st(`HS_GO, `HS_HI, `HS_RV, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_24C, 2'h1}:       step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_HF_F_LR_R, 2'h0}: step_of = st(`HS_GO, `HS_HI, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_HF_F_LR_R, 2'h1}: step_of = st(`HS_END, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_26AB, 2'h0}:      step_of = st(`HS_GO, `HS_HI, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            {`HS_SQ_26AB, 2'h1}:      step_of = st(`HS_GO, `HS_LO, `HS_RV, `HS_SIG_HOME, `HS_RISE);
            {`HS_SQ_26AB, 2'h2}:      step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_FALL);
            default:                  step_of = st(`HS_END, `HS_LO, `HS_FW, `HS_SIG_HOME, `HS_RISE);
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Switch synchronisers
   assign raw_sw = {REV_LIMIT, FWD_LIMIT, HOME_SW};

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_sw
         hs_sync_edge u_sync
         (
            .clk   (MCLK),
            .rst   (RST),
            .ce    (CE),
            .din   (raw_sw[g]),
            .level (sw_level[g]),
            .rise  (sw_rise[g]),
            .fall  (sw_fall[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Current step decode
   assign cur     = step_of(seq, idx);
   assign cur_sig = cur[`HS_ST_SIG_HI:`HS_ST_SIG_LO];
   assign hit     = cur[`HS_ST_RISE] ? pick(sw_rise, cur_sig) : pick(sw_fall, cur_sig);
   assign esc     = esc_of(method);
   // Only the opening high-speed search may turn back off a limit
   assign escape_now = esc[6] & ~escaped & (idx == 2'h0) & cur[`HS_ST_HIGH]
                     & pick(sw_level, esc[5:4]);
   // A limit in the travel direction that is not the target ends the run
   assign dir_lim   = cur[`HS_ST_FWD] ? `HS_SIG_FLIM : `HS_SIG_RLIM;
   assign lim_fault = pick(sw_level, dir_lim) & (cur_sig != dir_lim);
   assign start_ok  = method_ok(METHOD);

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   always @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         state     <= ST_IDLE;
         method    <= `HS_METHOD_RST;
         seq       <= `HS_SQ_RST;
         idx       <= 2'h0;
         escaped   <= 1'h0;
         MOVE      <= 1'h0;
         MOVE_FWD  <= 1'h0;
         MOVE_HIGH <= 1'h0;
         BRAKE     <= 1'h0;
         BUSY      <= 1'h0;
         DONE      <= 1'h0;
         ERROR     <= 1'h0;
      end
      else if (CE)
      begin
         case (state)
            ST_IDLE:
            begin
               MOVE  <= 1'h0;
               BRAKE <= 1'h0;
               // Method code is sampled only here, so it must be set up first
               if (START)
               begin
                  DONE <= 1'h0;
                  if (start_ok)
                  begin
                     method  <= METHOD;
                     seq     <= pick_seq(METHOD, pick(sw_level, start_sig(METHOD)));
                     idx     <= 2'h0;
                     escaped <= 1'h0;
                     ERROR   <= 1'h0;
                     BUSY    <= 1'h1;
                     state   <= ST_SEARCH;
                  end
                  else
                  begin
                     ERROR <= 1'h1;
                  end
               end
            end
            ST_SEARCH:
            begin
               if (hit)
               begin
                  MOVE <= 1'h0;
                  if (cur[`HS_ST_LAST])
                  begin
                     BUSY  <= 1'h0;
                     DONE  <= 1'h1;
                     state <= ST_IDLE;
                  end
                  else
                  begin
                     idx <= idx + 2'h1;
                     if (cur[`HS_ST_HIGH])
                     begin
                        BRAKE <= 1'h1;
                        state <= ST_BRAKE;
                     end
                  end
               end
               else if (escape_now)
               begin
                  MOVE    <= 1'h0;
                  seq     <= esc[3:0];
                  idx     <= 2'h0;
                  escaped <= 1'h1;
                  BRAKE   <= 1'h1;
                  state   <= ST_BRAKE;
               end
               else if (lim_fault)
               begin
                  MOVE  <= 1'h0;
                  BUSY  <= 1'h0;
                  ERROR <= 1'h1;
                  state <= ST_IDLE;
               end
               else
               begin
                  MOVE      <= 1'h1;
                  MOVE_FWD  <= cur[`HS_ST_FWD];
                  MOVE_HIGH <= cur[`HS_ST_HIGH];
               end
            end
            ST_BRAKE:
            begin
               // Reverse only once the axis reports standstill
               if (AT_ZERO)
               begin
                  BRAKE <= 1'h0;
                  state <= ST_SEARCH;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // hs_homing_sequencer

// ---- test/hs_homing_sequencer_checker.sv ----
// Checker for the homing sequencer: start handshake, brake and step timing.
// Assumes CE is held high by the bench; sees only the top module's ports.
`timescale 1ns/100ps
`include "hs_defines.vh"

module hs_homing_sequencer_checker
(
   input wire logic       MCLK,
   input wire logic       RST,
   input wire logic       CE,
   input wire logic       START,
   input wire logic [7:0] METHOD,
   input wire logic       HOME_SW,
   input wire logic       FWD_LIMIT,
   input wire logic       REV_LIMIT,
   input wire logic       AT_ZERO,
   input wire logic       MOVE,
   input wire logic       MOVE_FWD,
   input wire logic       MOVE_HIGH,
   input wire logic       BRAKE,
   input wire logic       BUSY,
   input wire logic       DONE,
   input wire logic       ERROR
);
   default clocking hs_cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

////////////////////////////////////////////////////////////////////////
   a_start_accept: assert property (CE && START && !BUSY && METHOD >= `HS_M17 && METHOD <= `HS_M27
      |=> BUSY && !DONE && !ERROR)
      else $error("accepted start did not raise busy");
   a_code_reject: assert property (CE && START && !BUSY && (METHOD < `HS_M17 || METHOD > `HS_M27)
      |=> ERROR && !BUSY && !MOVE)
      else $error("bad method code not refused");
   a_idle_still: assert property (!BUSY |-> !MOVE)
      else $error("motion requested while idle");
   a_done_stop: assert property ($rose(DONE) |-> !BUSY && $past(BUSY) && !MOVE)
      else $error("done raised outside final stop");
   a_first_step: assert property ($rose(BUSY) |=> MOVE)
      else $error("first step did not start");
   // A high speed step may not turn round without a stop to zero
   a_brake_high: assert property ($fell(MOVE) && $past(MOVE_HIGH) && BUSY |-> BRAKE)
      else $error("high speed step ended without brake");
   a_low_gap: assert property ($fell(MOVE) && !$past(MOVE_HIGH) && BUSY |-> !BRAKE ##1 MOVE)
      else $error("low speed turn not a single idle cycle");
   a_brake_hold: assert property (BRAKE && !AT_ZERO |=> BRAKE && !MOVE)
      else $error("brake released before standstill");
   a_brake_release: assert property (BRAKE && AT_ZERO |=> !BRAKE ##1 MOVE)
      else $error("no next step after standstill");
endmodule // hs_homing_sequencer_checker

bind hs_homing_sequencer hs_homing_sequencer_checker hs_homing_sequencer_checker_inst
(
   .MCLK(MCLK), .RST(RST), .CE(CE), .START(START), .METHOD(METHOD), .HOME_SW(HOME_SW),
   .FWD_LIMIT(FWD_LIMIT), .REV_LIMIT(REV_LIMIT), .AT_ZERO(AT_ZERO), .MOVE(MOVE), .MOVE_FWD(MOVE_FWD),
   .MOVE_HIGH(MOVE_HIGH), .BRAKE(BRAKE), .BUSY(BUSY), .DONE(DONE), .ERROR(ERROR)
);

// ---- test/hs_axis_model.sv ----
// Behavioural axis: position integrator with home window and end limits.
// Assumes one MCLK domain; stops dead when motion drops, standstill later.
`timescale 1ns/100ps

module hs_axis_model
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               move,
   input  wire logic               move_fwd,
   input  wire logic               move_high,
   input  wire logic               ld,
   input  wire logic signed [31:0] ld_pos,
   input  wire logic               slow,
   output logic signed [31:0]      pos,
   output wire logic               home_sw,
   output wire logic               fwd_limit,
   output wire logic               rev_limit,
   output wire logic               at_zero
);
   logic        [5:0]  still;
   wire  signed [31:0] step;

////////////////////////////////////////////////////////////////////////
   // Home window wider than the worst overshoot at high speed
   assign home_sw   = pos >= 100 && pos <= 199;
   assign fwd_limit = pos >= 400;
   assign rev_limit = pos <= -400;
   assign step      = move_high ? 32'sh4 : 32'sh1;
   // Slow mode stretches deceleration so a long brake phase is seen
   assign at_zero   = !move && still >= (slow ? 6'h19 : 6'h02);

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pos   <= 32'sh0;
         still <= 6'h00;
      end
      else if (ld)
         pos <= ld_pos;
      else if (move)
      begin
         pos   <= move_fwd ? pos + step : pos - step;
         still <= 6'h00;
      end
      else if (still != 6'h3F)
         still <= still + 6'h01;
   end
endmodule // hs_axis_model

// ---- test/hs_homing_sequencer_tb.sv ----
// Self-checking bench for the homing sequencer against the axis model.
// Assumes CE tied high; step codes are {1,high,fwd} per started move.
`timescale 1ns/100ps
`include "hs_defines.vh"

module hs_homing_sequencer_tb;
   logic               MCLK;
   logic               RST;
   logic               CE;
   logic               START;
   logic        [7:0]  METHOD;
   wire                HOME_SW, FWD_LIMIT, REV_LIMIT, AT_ZERO;
   wire                MOVE, MOVE_FWD, MOVE_HIGH, BRAKE, BUSY, DONE, ERROR;
   logic               ld;
   logic signed [31:0] ld_pos;
   logic               slow;
   wire  signed [31:0] pos;
   logic        [15:0] seq;
   logic               prev_move;
   int                 error_cnt;
   int                 tests_run;

   hs_homing_sequencer hs_homing_sequencer_inst
   (
      .MCLK(MCLK), .RST(RST), .CE(CE), .START(START), .METHOD(METHOD), .HOME_SW(HOME_SW),
      .FWD_LIMIT(FWD_LIMIT), .REV_LIMIT(REV_LIMIT), .AT_ZERO(AT_ZERO), .MOVE(MOVE), .MOVE_FWD(MOVE_FWD),
      .MOVE_HIGH(MOVE_HIGH), .BRAKE(BRAKE), .BUSY(BUSY), .DONE(DONE), .ERROR(ERROR)
   );

   hs_axis_model hs_axis_model_inst
   (
      .clk(MCLK), .rst(RST), .move(MOVE), .move_fwd(MOVE_FWD), .move_high(MOVE_HIGH), .ld(ld),
      .ld_pos(ld_pos), .slow(slow), .pos(pos), .home_sw(HOME_SW), .fwd_limit(FWD_LIMIT),
      .rev_limit(REV_LIMIT), .at_zero(AT_ZERO)
   );

////////////////////////////////////////////////////////////////////////
   initial
   begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   // Log each started move so the whole step order is compared at once;
   // the axis load pulse clears the log so only this process drives it
   always @(posedge MCLK)
   begin
      prev_move <= MOVE;
      if (ld === 1'b1)
         seq <= 16'h0000;
      else if (MOVE === 1'b1 && prev_move !== 1'b1)
         seq <= {seq[12:0], 1'b1, MOVE_HIGH, MOVE_FWD};
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Place the axis, let the synchronisers settle, start, wait for the end
   task automatic run_case(input logic [7:0] m, input int p, input logic [15:0] es, input int e,
                           input logic ok, input logic poke);
      int n;
      @(posedge MCLK);
      ld     <= 1'b1;
      ld_pos <= p;
      @(posedge MCLK);
      ld <= 1'b0;
      repeat (5) @(posedge MCLK);
      METHOD <= m;
      START  <= 1'b1;
      @(posedge MCLK);
      START <= 1'b0;
      n = 0;
      do
      begin
         @(negedge MCLK);
         n++;
         if (poke && n == 20)
         begin
            @(posedge MCLK);
            METHOD <= `HS_M16;
            START  <= 1'b1;
            @(posedge MCLK);
            START <= 1'b0;
         end
      end
      while (BUSY === 1'b1 && n < 5000);
      check(BUSY, 1'b0);
      check(DONE, ok);
      check(ERROR, !ok);
      check(seq, es);
      if (ok)
         check(pos >= e - 8 && pos <= e + 8, 1'b1);
   endtask

   task automatic t_reject;
      logic [7:0] codes [4] = '{`HS_M16, `HS_METHOD_RST, 8'h1C, 8'hFF};
      foreach (codes[i])
      begin
         @(posedge MCLK);
         METHOD <= codes[i];
         START  <= 1'b1;
         @(posedge MCLK);
         START <= 1'b0;
         @(negedge MCLK);
         check({BUSY, ERROR, MOVE}, 3'h2);
      end
      $display("test reject done");
   endtask

   task automatic t_limit_methods;
      run_case(`HS_M17, 0, 16'h0035, -399, 1'b1, 1'b0);
      run_case(`HS_M17, -420, 16'h0005, -399, 1'b1, 1'b0);
      run_case(`HS_M18, 0, 16'h003C, 399, 1'b1, 1'b0);
      run_case(`HS_M18, 420, 16'h0004, 399, 1'b1, 1'b0);
      $display("test limit_methods done");
   endtask

   task automatic t_home_single;
      run_case(`HS_M19, 0, 16'h003C, 99, 1'b1, 1'b0);
      run_case(`HS_M19, 150, 16'h0004, 99, 1'b1, 1'b0);
      run_case(`HS_M21, 300, 16'h0035, 200, 1'b1, 1'b0);
      run_case(`HS_M21, 150, 16'h0005, 200, 1'b1, 1'b0);
      run_case(`HS_M23, 0, 16'h003C, 99, 1'b1, 1'b0);
      run_case(`HS_M23, 150, 16'h0004, 99, 1'b1, 1'b0);
      run_case(`HS_M27, 300, 16'h0035, 200, 1'b1, 1'b0);
      run_case(`HS_M27, 150, 16'h0005, 200, 1'b1, 1'b0);
      $display("test home_single done");
   endtask

   task automatic t_home_double;
      run_case(`HS_M20, 0, 16'h01E5, 100, 1'b1, 1'b0);
      run_case(`HS_M20, 150, 16'h0025, 100, 1'b1, 1'b0);
      run_case(`HS_M22, 300, 16'h01AC, 199, 1'b1, 1'b0);
      run_case(`HS_M22, 150, 16'h002C, 199, 1'b1, 1'b0);
      run_case(`HS_M24, 0, 16'h01E5, 100, 1'b1, 1'b0);
      run_case(`HS_M24, 150, 16'h0025, 100, 1'b1, 1'b0);
      $display("test home_double done");
   endtask

   task automatic t_fall_first;
      run_case(`HS_M25, 0, 16'h003C, 199, 1'b1, 1'b0);
      run_case(`HS_M25, 150, 16'h003C, 199, 1'b1, 1'b0);
      run_case(`HS_M26, 0, 16'h01E5, 200, 1'b1, 1'b0);
      run_case(`HS_M26, 150, 16'h01E5, 200, 1'b1, 1'b0);
      $display("test fall_first done");
   endtask

   // Start beyond the home window so the search runs into a limit
   task automatic t_escape;
      run_case(`HS_M23, 300, 16'h0FAC, 99, 1'b1, 1'b0);
      run_case(`HS_M24, 300, 16'h01F5, 100, 1'b1, 1'b0);
      run_case(`HS_M25, 300, 16'h0FAC, 199, 1'b1, 1'b0);
      run_case(`HS_M26, 300, 16'h01F5, 200, 1'b1, 1'b0);
      run_case(`HS_M27, 0, 16'h01BC, 199, 1'b1, 1'b0);
      $display("test escape done");
   endtask

   task automatic t_misc;
      run_case(`HS_M19, 300, 16'h0007, 0, 1'b0, 1'b0);
      run_case(`HS_M19, 0, 16'h003C, 99, 1'b1, 1'b1);
      slow <= 1'b1;
      run_case(`HS_M20, 0, 16'h01E5, 100, 1'b1, 1'b0);
      slow <= 1'b0;
      @(posedge MCLK);
      METHOD <= `HS_M20;
      START  <= 1'b1;
      @(posedge MCLK);
      START <= 1'b0;
      repeat (10) @(posedge MCLK);
      RST <= 1'b1;
      @(negedge MCLK);
      check({MOVE, BRAKE, BUSY, DONE, ERROR}, 5'h00);
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(negedge MCLK);
      check({MOVE, BRAKE, BUSY, DONE, ERROR}, 5'h00);
      $display("test misc done");
   endtask

   initial
   begin
      RST       = 1'b1;
      CE        = 1'b1;
      START     = 1'b0;
      METHOD    = 8'h00;
      ld        = 1'b0;
      ld_pos    = 32'sh0;
      slow      = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      repeat (5) @(posedge MCLK);
      RST <= 1'b0;
      @(negedge MCLK);
      check({MOVE, BRAKE, BUSY, DONE, ERROR}, 5'h00);
      t_reject;
      t_limit_methods;
      t_home_single;
      t_home_double;
      t_fall_first;
      t_escape;
      t_misc;
      finish_test;
   end

   // About 30 runs of at most a few hundred cycles each; 40,000 cycles is ample
   initial
   begin
      #400000;
      error_cnt++;
      finish_test;
   end
endmodule // hs_homing_sequencer_tb
